//--- rtl/b1r_bank.sv
// Purpose: Bank-one special register file of a small microcontroller core.
// Assumes: Core strobes are one-cycle pulses synchronous to mclk.
// Notes: Peripherals behind these registers live elsewhere; this block only holds state.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps

module b1r_bank #(
    parameter bit HAS_CONVERTER = 1'b1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire b1r_pkg::b1r_core_t core,
    input wire b1r_pkg::b1r_periph_t periph,
    input wire logic [7:0] ind_rdata,
    output logic [8:0] indirect_addr,
    output logic ind_we,
    output logic [7:0] ind_wdata,
    output logic [12:0] program_counter,
    output logic [7:0] port_a_direction,
    output b1r_pkg::b1r_view_t reg_view
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    b1r_pkg::b1r_req_t req;
    logic [7:0] rdata, ind_wdata_ff;
    logic [7:0] regs_ff [b1r_pkg::NREG];
    logic [7:0] hw_val [b1r_pkg::NREG], rd_val [b1r_pkg::NREG];
    logic [7:0] wmask [b1r_pkg::NREG], rmask [b1r_pkg::NREG];
    logic [b1r_pkg::NREG-1:0] hit;
    logic [1:0] bank_sel;
    logic in_window, hit_pcl, hit_indirect_access_port, to_ff, pd_ff, ind_we_ff;
    logic [12:0] pc_ff;

    // ------------------------------------------------------------------
    // Bus front end.
    // ------------------------------------------------------------------

    // The slave owns the handshake; this module only sees strobes and read data.
    b1r_ahb_slave u_slave (
        .mclk(mclk),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .req(req),
        .rdata(rdata)
    );

    // ------------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------------

    // Current bank comes from the two bank select bits of the status register.
    assign bank_sel = {regs_ff[b1r_pkg::IDX_STATUS][b1r_pkg::STATUS_BANK_HI_BIT],
                       regs_ff[b1r_pkg::IDX_STATUS][b1r_pkg::STATUS_BANK_LO_BIT]};

    // Indices below the bank window are unmapped and read as zero.
    assign in_window = (req.idx[7] == b1r_pkg::BANK_WINDOW);

    // The indirect port and counter low byte have no stored copy here but decode in any bank.
    assign hit_pcl = in_window && (req.idx == b1r_pkg::OFF_PC_LOW);
    assign hit_indirect_access_port = in_window && (req.idx == b1r_pkg::OFF_INDIRECT_PORT);

    // ------------------------------------------------------------------
    // Per-register masks, decode and storage.
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < b1r_pkg::NREG; gi++) begin : g_reg

            // Without the converter the conversion enable bit does not exist at all.
            if (gi == b1r_pkg::IDX_PIE_ONE && !HAS_CONVERTER) begin : g_noconv
                assign wmask[gi] = b1r_pkg::REG_WMASK[gi] &
                                   ~(8'h01 << b1r_pkg::PERIPHERAL_IRQ_ENABLE_ONE_CONV_BIT);
                assign rmask[gi] = b1r_pkg::REG_RMASK[gi] &
                                   ~(8'h01 << b1r_pkg::PERIPHERAL_IRQ_ENABLE_ONE_CONV_BIT);
            end else begin : g_full
                assign wmask[gi] = b1r_pkg::REG_WMASK[gi];
                assign rmask[gi] = b1r_pkg::REG_RMASK[gi];
            end

            // Mirrored registers ignore the bank bits; the others need bank one.
            assign hit[gi] = in_window && (req.idx == b1r_pkg::REG_OFF[gi]) &&
                             (b1r_pkg::REG_MIRROR[gi] ||
                              bank_sel == b1r_pkg::BANK_ONE);

            // Only writable bits are stored; hardware-owned bits keep their reset value.
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_ff[gi] <= b1r_pkg::REG_RESET[gi];
                end else if (req.wr && hit[gi]) begin
                    regs_ff[gi] <= (regs_ff[gi] & ~wmask[gi]) |
                                   (req.wdata & wmask[gi]);
                end
            end

            // Read value merges stored and hardware bits, then drops missing bits.
            assign rd_val[gi] = ((regs_ff[gi] & wmask[gi]) |
                                 (hw_val[gi] & ~wmask[gi])) & rmask[gi];
            assign reg_view[gi] = rd_val[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Hardware-owned bits.
    // ------------------------------------------------------------------

    // Status, oscillator and serial flags come from outside; pin 5 can never drive.
    always_comb begin
        for (int i = 0; i < b1r_pkg::NREG; i++) begin
            hw_val[i] = 8'h00;
        end
        hw_val[b1r_pkg::IDX_STATUS][b1r_pkg::STATUS_TO_BIT] = to_ff;
        hw_val[b1r_pkg::IDX_STATUS][b1r_pkg::STATUS_PD_BIT] = pd_ff;
        hw_val[b1r_pkg::IDX_PORT_A_DIR][b1r_pkg::PORT_A_PIN5] = 1'b1;
        hw_val[b1r_pkg::IDX_OSC_CTRL][b1r_pkg::OSC_OSTS_BIT] = periph.osc_startup_done;
        hw_val[b1r_pkg::IDX_OSC_CTRL][b1r_pkg::OSC_IOFS_BIT] = periph.intosc_stable;
        hw_val[b1r_pkg::IDX_SER_STATUS][b1r_pkg::SER_HW_BITS-1:0] = periph.serial_state;
    end

    // Timeout flag: cleared by a watchdog timeout, set again by a watchdog clear.
    // A timeout in the same cycle as a clear wins, so the event is never lost.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            to_ff <= 1'b1;
        end else if (core.wdt_timeout) begin
            to_ff <= 1'b0;
        end else if (core.wdt_clear) begin
            to_ff <= 1'b1;
        end
    end

    // Power-down flag: cleared on entry to sleep, set by a watchdog clear.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pd_ff <= 1'b1;
        end else if (core.sleep_entry) begin
            pd_ff <= 1'b0;
        end else if (core.wdt_clear) begin
            pd_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Program counter.
    // ------------------------------------------------------------------

    // A low-byte write loads the counter; its upper bits come only from the latch.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pc_ff <= b1r_pkg::PC_RESET;
        end else if (req.wr && hit_pcl) begin
            pc_ff <= {regs_ff[b1r_pkg::IDX_PC_HIGH_LATCH][b1r_pkg::LATCH_WIDTH-1:0],
                      req.wdata};
        end else if (core.pc_inc) begin
            pc_ff <= pc_ff + 13'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Indirect access port.
    // ------------------------------------------------------------------

    // A port write becomes a memory write strobe a cycle later, kept off the bus path.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ind_we_ff <= 1'b0;
            ind_wdata_ff <= 8'h00;
        end else begin
            ind_we_ff <= req.wr && hit_indirect_access_port;
            if (req.wr && hit_indirect_access_port) begin
                ind_wdata_ff <= req.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read mux.
    // ------------------------------------------------------------------

    // At most one hit is live; a miss reads zero. The upper counter byte has no path.
    always_comb begin
        rdata = 8'h00;
        for (int i = 0; i < b1r_pkg::NREG; i++) begin
            if (hit[i]) begin
                rdata = rd_val[i];
            end
        end
        if (hit_pcl) begin
            rdata = pc_ff[7:0];
        end
        if (hit_indirect_access_port) begin
            rdata = ind_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------

    // The pointer is widened by the status bank bit for indirect addressing.
    assign indirect_addr = {regs_ff[b1r_pkg::IDX_STATUS][b1r_pkg::STATUS_IRP_BIT],
                            regs_ff[b1r_pkg::IDX_POINTER]};
    assign ind_we = ind_we_ff;
    assign ind_wdata = ind_wdata_ff;
    assign program_counter = pc_ff;

    // Direction bits 4:0, 6 and 7 pass through to their pins; bit 5 reads one.
    assign port_a_direction = rd_val[b1r_pkg::IDX_PORT_A_DIR];

endmodule

//--- inc/b1r_pkg.sv
// Purpose: Constants, register table and carrier types for the bank-one register block.
// Assumes: 8-bit register file reached as one 32-bit AHB-Lite word per register.
// Notes: Printed offsets are register indices; the byte address is four times the index.
//
// Notes on behaviour
// - Unimplemented bits and unused addresses in this bank always read as zero.
// - High latch holds pending counter bits 12:8, copied in on a low-byte load.
// - Counter upper byte is never read or written directly, only via the latch.
// - Indirect port, counter low, status, pointer, latch, interrupt control: all banks.
// - Port A pin 5 is input only; its direction bit reads back as one.
// - Conversion interrupt enable exists only on the variant with the converter.
// - Port A direction bits 4:0 steer pins 4:0; bits 6 and 7 steer pins 6 and 7.

package b1r_pkg;

    // ------------------------------------------------------------------
    // Printed register offsets (register indices).
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_INDIRECT_PORT = 8'h80;
    localparam logic [7:0] OFF_OPTION = 8'h81;
    localparam logic [7:0] OFF_PC_LOW = 8'h82;
    localparam logic [7:0] OFF_STATUS = 8'h83;
    localparam logic [7:0] OFF_POINTER = 8'h84;
    localparam logic [7:0] OFF_PORT_A_DIR = 8'h85;
    localparam logic [7:0] OFF_PORT_B_DIR = 8'h86;
    localparam logic [7:0] OFF_PC_HIGH_LATCH = 8'h8A;
    localparam logic [7:0] OFF_CORE_IRQ = 8'h8B;
    localparam logic [7:0] OFF_PIE_ONE = 8'h8C;
    localparam logic [7:0] OFF_PIE_TWO = 8'h8D;
    localparam logic [7:0] OFF_POWER_FLAGS = 8'h8E;
    localparam logic [7:0] OFF_OSC_CTRL = 8'h8F;
    localparam logic [7:0] OFF_OSC_TUNE = 8'h90;
    localparam logic [7:0] OFF_T2_PERIOD = 8'h92;
    localparam logic [7:0] OFF_SER_ADDR = 8'h93;
    localparam logic [7:0] OFF_SER_STATUS = 8'h94;

    // ------------------------------------------------------------------
    // Stored register table, one entry per physical register.
    // ------------------------------------------------------------------
    localparam int NREG = 15;
    localparam int IDX_OPTION = 0;
    localparam int IDX_STATUS = 1;
    localparam int IDX_POINTER = 2;
    localparam int IDX_PORT_A_DIR = 3;
    localparam int IDX_PORT_B_DIR = 4;
    localparam int IDX_PC_HIGH_LATCH = 5;
    localparam int IDX_CORE_IRQ = 6;
    localparam int IDX_PIE_ONE = 7;
    localparam int IDX_PIE_TWO = 8;
    localparam int IDX_POWER_FLAGS = 9;
    localparam int IDX_OSC_CTRL = 10;
    localparam int IDX_OSC_TUNE = 11;
    localparam int IDX_T2_PERIOD = 12;
    localparam int IDX_SER_ADDR = 13;
    localparam int IDX_SER_STATUS = 14;

    localparam logic [7:0] REG_OFF [NREG] = '{OFF_OPTION, OFF_STATUS, OFF_POINTER,
        OFF_PORT_A_DIR, OFF_PORT_B_DIR, OFF_PC_HIGH_LATCH, OFF_CORE_IRQ, OFF_PIE_ONE,
        OFF_PIE_TWO, OFF_POWER_FLAGS, OFF_OSC_CTRL, OFF_OSC_TUNE, OFF_T2_PERIOD,
        OFF_SER_ADDR, OFF_SER_STATUS};
    localparam logic [7:0] REG_RESET [NREG] = '{8'hFF, 8'h18, 8'h00, 8'hFF, 8'hFF, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
    // Bits that exist at all; the rest read as zero.
    localparam logic [7:0] REG_RMASK [NREG] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F,
        8'hFF, 8'h7F, 8'hD0, 8'h03, 8'h7F, 8'h3F, 8'hFF, 8'hFF, 8'hFF};
    // Bits that software may write; existing bits outside it come from hardware.
    localparam logic [7:0] REG_WMASK [NREG] = '{8'hFF, 8'hE7, 8'hFF, 8'hDF, 8'hFF, 8'h1F,
        8'hFF, 8'h7F, 8'hD0, 8'h03, 8'h73, 8'h3F, 8'hFF, 8'hFF, 8'hC0};
    localparam logic REG_MIRROR [NREG] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1,
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    // ------------------------------------------------------------------
    // Field positions and fixed values.
    // ------------------------------------------------------------------
    localparam int STATUS_IRP_BIT = 7;
    localparam int STATUS_BANK_HI_BIT = 6;
    localparam int STATUS_BANK_LO_BIT = 5;
    localparam int STATUS_TO_BIT = 4;
    localparam int STATUS_PD_BIT = 3;
    localparam logic [1:0] BANK_ONE = 2'h1;
    localparam int PERIPHERAL_IRQ_ENABLE_ONE_CONV_BIT = 6;
    localparam int PORT_A_PIN5 = 5;
    localparam int OSC_OSTS_BIT = 3;
    localparam int OSC_IOFS_BIT = 2;
    localparam int SER_HW_BITS = 6;
    localparam int LATCH_WIDTH = 5;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic BANK_WINDOW = 1'b1;

    // ------------------------------------------------------------------
    // Carrier types.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic [7:0] idx;
        logic [7:0] wdata;
    } b1r_req_t;

    typedef struct packed {
        logic pc_inc;
        logic wdt_timeout;
        logic sleep_entry;
        logic wdt_clear;
    } b1r_core_t;

    typedef struct packed {
        logic osc_startup_done;
        logic intosc_stable;
        logic [5:0] serial_state;
    } b1r_periph_t;

    typedef logic [NREG-1:0][7:0] b1r_view_t;

endpackage

//--- rtl/b1r_ahb_slave.sv
// Purpose: AHB-Lite slave front end that turns bus transfers into register strobes.
// Assumes: Single whole-word transfers; response is always OKAY.
// Notes: Writes take no wait state; reads take one so that hrdata comes from a flip-flop.
`timescale 1ns/10ps

module b1r_ahb_slave (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output b1r_pkg::b1r_req_t req,
    input wire logic [7:0] rdata
);

    logic accept, dph_wr_ff, dph_rd_ff, rd_done_ff;
    logic [7:0] dph_idx_ff;
    logic [31:0] hrdata_ff;

    // ------------------------------------------------------------------
    // Address phase capture.
    // ------------------------------------------------------------------

    // NONSEQ or SEQ with hready high opens a data phase; hsize is not checked.
    assign accept = hsel & htrans[1] & hready;

    // Data phase state; a new address phase may overlap the last data cycle.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dph_wr_ff <= 1'b0;
            dph_rd_ff <= 1'b0;
            dph_idx_ff <= 8'h00;
        end else if (accept) begin
            dph_wr_ff <= hwrite;
            dph_rd_ff <= ~hwrite;
            dph_idx_ff <= haddr[9:2];
        end else if (hreadyout) begin
            dph_wr_ff <= 1'b0;
            dph_rd_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read wait state and data register.
    // ------------------------------------------------------------------

    // The first read data cycle stalls and samples the register file.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_done_ff <= 1'b0;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            rd_done_ff <= dph_rd_ff & ~rd_done_ff;
            if (dph_rd_ff && !rd_done_ff) begin
                hrdata_ff <= {24'h00_0000, rdata};
            end
        end
    end

    // Strobes toward the register file; the write lands at the end of its data phase.
    assign hreadyout = ~(dph_rd_ff & ~rd_done_ff);
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign req.wr = dph_wr_ff;
    assign req.idx = dph_idx_ff;
    assign req.wdata = hwdata[7:0];

endmodule

//--- test/b1r_bank_chk.sv
// Purpose: Port assertions for the bank-one register block.
// Assumes: One clock; the bus hready is the block's own hreadyout.
// Notes: Bound to b1r_bank below the module.
`timescale 1ns/10ps

module b1r_bank_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire b1r_pkg::b1r_core_t core,
    input wire logic [8:0] indirect_addr,
    input wire logic ind_we,
    input wire logic [7:0] ind_wdata,
    input wire logic [12:0] program_counter,
    input wire logic [7:0] port_a_direction,
    input wire b1r_pkg::b1r_view_t reg_view
);
    // ----------------------------------------------------------
    // Data-phase tracker
    // ----------------------------------------------------------
    logic dph_ff, dwr_ff, take, wdone, gated, unused_a;
    logic [7:0] didx_ff, aidx, hw8, opt_w;
    logic [4:0] latch_w;

    // Plain signals for $past, and the decoded bus events.
    assign aidx = haddr[9:2];
    assign hw8 = hwdata[7:0];
    assign latch_w = reg_view[b1r_pkg::IDX_PC_HIGH_LATCH][4:0];
    assign opt_w = reg_view[b1r_pkg::IDX_OPTION];
    assign gated = reg_view[b1r_pkg::IDX_STATUS][6:5] != b1r_pkg::BANK_ONE;
    assign take = hsel && htrans[1] && hready;
    assign wdone = dph_ff && dwr_ff && hready;
    assign unused_a = aidx < 8'h80 || aidx > 8'h94 || aidx inside {8'h87, 8'h88, 8'h89, 8'h91};

    // The address phase advances only while hready is high.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dph_ff <= 1'b0;
            dwr_ff <= 1'b0;
            didx_ff <= 8'h00;
        end else if (hready) begin
            dph_ff <= take;
            dwr_ff <= hwrite;
            didx_ff <= aidx;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    property p_hi_zero;
        hrdata[31:8] == 24'h000000;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");

    property p_unused;
        take && !hwrite && unused_a |=> !hreadyout ##1 (hreadyout && hrdata == 32'h00000000);
    endproperty
    a_unused: assert property (p_unused) else $error("unused place read nonzero");

    property p_latch_top;
        reg_view[b1r_pkg::IDX_PC_HIGH_LATCH][7:5] == 3'h0;
    endproperty
    a_latch_top: assert property (p_latch_top) else $error("latch top bits set");

    property p_pc_load;
        wdone && didx_ff == b1r_pkg::OFF_PC_LOW |=>
            program_counter == {$past(latch_w), $past(hw8)};
    endproperty
    a_pc_load: assert property (p_pc_load) else $error("counter load wrong");

    property p_pc_hold;
        !core.pc_inc && !(wdone && didx_ff == b1r_pkg::OFF_PC_LOW) |=> $stable(program_counter);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("counter moved unasked");

    property p_ind_wr;
        wdone && didx_ff == b1r_pkg::OFF_INDIRECT_PORT |=> ind_we && ind_wdata == $past(hw8);
    endproperty
    a_ind_wr: assert property (p_ind_wr) else $error("indirect write lost");

    property p_ind_addr;
        indirect_addr == {reg_view[b1r_pkg::IDX_STATUS][7], reg_view[b1r_pkg::IDX_POINTER]};
    endproperty
    a_ind_addr: assert property (p_ind_addr) else $error("indirect address wrong");

    property p_pa5;
        port_a_direction[5] && reg_view[b1r_pkg::IDX_PORT_A_DIR][5];
    endproperty
    a_pa5: assert property (p_pa5) else $error("pin 5 direction not one");

    property p_gate;
        wdone && didx_ff == b1r_pkg::OFF_OPTION && gated |=> $stable(opt_w);
    endproperty
    a_gate: assert property (p_gate) else $error("banked write outside bank one");

    c_pc_load: cover property (wdone && didx_ff == b1r_pkg::OFF_PC_LOW);
    c_gate: cover property (wdone && didx_ff == b1r_pkg::OFF_OPTION && gated);
    c_ind: cover property (ind_we);
endmodule

bind b1r_bank b1r_bank_chk u_chk (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .core(core), .indirect_addr(indirect_addr), .ind_we(ind_we),
    .ind_wdata(ind_wdata), .program_counter(program_counter),
    .port_a_direction(port_a_direction), .reg_view(reg_view)
);

//--- test/b1r_bank_tb.sv
// Purpose: Self-checking bench for the bank-one register block over AHB-Lite.
// Assumes: Register byte address is four times its printed offset.
// Notes: Core strobes stay idle, so the counter only moves on loads.
`timescale 1ns/10ps

module b1r_bank_tb;
    localparam logic [7:0] UNUSED [6] = '{8'h87, 8'h88, 8'h89, 8'h91, 8'h95, 8'h10};
    logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, ind_we;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rnd;
    b1r_pkg::b1r_core_t core;
    b1r_pkg::b1r_periph_t periph;
    logic [7:0] ind_rdata, ind_wdata, port_a_direction, d;
    logic [8:0] indirect_addr;
    logic [12:0] program_counter;
    b1r_pkg::b1r_view_t reg_view;
    logic [7:0] mdl [15];
    integer seed;
    int miscompares, cmp_count, cyc;

    b1r_bank DUT (
        .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core(core),
        .periph(periph), .ind_rdata(ind_rdata), .indirect_addr(indirect_addr),
        .ind_we(ind_we), .ind_wdata(ind_wdata), .program_counter(program_counter),
        .port_a_direction(port_a_direction), .reg_view(reg_view)
    );

    // Free-running 100 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Hang guard.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One single transfer; waits on hready, never on a fixed latency.
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [31:0] q);
        logic [31:0] r;
        r = $random(seed);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {r[31:8], wd};
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        q = hrdata;
        chk(32'(hresp), 32'h0);
    endtask

    task automatic wr8(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] q;
        xfer(1'b1, idx, wd, q);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] q;
        xfer(1'b0, idx, 8'h00, q);
        chk(q, 32'(e));
    endtask

    // Only writable bits change.
    function automatic void upd(input int i, input logic [7:0] wd);
        mdl[i] = (wd & b1r_pkg::REG_WMASK[i]) | (mdl[i] & ~b1r_pkg::REG_WMASK[i]);
    endfunction

    task automatic wr_reg(input int i, input logic [7:0] wd);
        wr8(b1r_pkg::REG_OFF[i], wd);
        upd(i, wd);
    endtask

    // Read value with absent and hardware-owned bits applied.
    function automatic logic [7:0] exp_rd(input int i);
        logic [7:0] v;
        v = mdl[i] & b1r_pkg::REG_RMASK[i];
        if (i == b1r_pkg::IDX_PORT_A_DIR) v[5] = 1'b1;
        if (i == b1r_pkg::IDX_OSC_CTRL) v[3:2] = {periph.osc_startup_done, periph.intosc_stable};
        if (i == b1r_pkg::IDX_SER_STATUS) v[5:0] = periph.serial_state;
        return v;
    endfunction

    // Main sequence.
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        core = '0;
        periph = '0;
        ind_rdata = 8'h00;
        miscompares = 0;
        cmp_count = 0;
        seed = 32'hC71D613A;
        for (int i = 0; i < 15; i++) mdl[i] = b1r_pkg::REG_RESET[i];
        repeat (6) @(posedge mclk);
        rnd = $random(seed);
        rst_n <= 1'b1;
        periph <= rnd[7:0];
        // Bank zero: mirrored status answers, option does not.
        rdchk(b1r_pkg::OFF_STATUS, 8'h18);
        rdchk(b1r_pkg::OFF_OPTION, 8'h00);
        wr_reg(b1r_pkg::IDX_STATUS, 8'h20);
        for (int i = 0; i < 15; i++) rdchk(b1r_pkg::REG_OFF[i], exp_rd(i));
        // Random write and read-back, bank one kept.
        repeat (3) begin
            for (int i = 0; i < 15; i++) begin
                rnd = $random(seed);
                d = rnd[7:0];
                if (i == b1r_pkg::IDX_STATUS) d[6:5] = 2'b01;
                wr_reg(i, d);
                rdchk(b1r_pkg::REG_OFF[i], exp_rd(i));
            end
            chk(32'(port_a_direction), 32'(exp_rd(b1r_pkg::IDX_PORT_A_DIR)));
        end
        // Clearing every direction bit still leaves pin 5 as an input.
        wr_reg(b1r_pkg::IDX_PORT_A_DIR, 8'h00);
        rdchk(b1r_pkg::OFF_PORT_A_DIR, 8'h20);
        chk(32'(port_a_direction), 32'h00000020);
        wr_reg(b1r_pkg::IDX_PIE_ONE, 8'hFF);
        rdchk(b1r_pkg::OFF_PIE_ONE, 8'h7F);
        // Latch corners; the counter is checked once its load edge has passed.
        for (int k = 0; k < 3; k++) begin
            rnd = $random(seed);
            d = (k == 0) ? 8'hFF : ((k == 1) ? 8'h00 : rnd[7:0]);
            wr_reg(b1r_pkg::IDX_PC_HIGH_LATCH, d);
            rdchk(b1r_pkg::OFF_PC_HIGH_LATCH, d & 8'h1F);
            wr8(b1r_pkg::OFF_PC_LOW, rnd[15:8]);
            rdchk(b1r_pkg::OFF_PC_LOW, rnd[15:8]);
            chk(32'(program_counter), 32'({d[4:0], rnd[15:8]}));
        end
        // Each bank: mirrored places answer, option only in bank one.
        for (int b = 0; b < 4; b++) begin
            rnd = $random(seed);
            d = rnd[7:0];
            d[6:5] = 2'(b);
            wr_reg(b1r_pkg::IDX_STATUS, d);
            rdchk(b1r_pkg::OFF_STATUS, exp_rd(b1r_pkg::IDX_STATUS));
            wr_reg(b1r_pkg::IDX_POINTER, rnd[15:8]);
            rdchk(b1r_pkg::OFF_POINTER, rnd[15:8]);
            wr8(b1r_pkg::OFF_INDIRECT_PORT, rnd[23:16]);
            ind_rdata <= rnd[31:24];
            rdchk(b1r_pkg::OFF_INDIRECT_PORT, rnd[31:24]);
            wr8(b1r_pkg::OFF_OPTION, rnd[23:16]);
            if (b == 1) upd(b1r_pkg::IDX_OPTION, rnd[23:16]);
            d = (b == 1) ? exp_rd(b1r_pkg::IDX_OPTION) : 8'h00;
            rdchk(b1r_pkg::OFF_OPTION, d);
            for (int k = 0; k < 6; k++) begin
                wr8(UNUSED[k], rnd[7:0]);
                rdchk(UNUSED[k], 8'h00);
            end
        end
        end_of_test();
    end
endmodule
